// ===== spc_checker.sv
/*
 spc_checker: checks setup, sampling, equation and retrieval lists
 and keeps the latest error code for a status read.
 assumes parameters are written before the command word.
*/
`timescale 1ns/100ps
module spc_checker #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	// register port
	input  wire spc_p::spc_bus_t   bus_req,
	output logic [31:0]            rd_data,
	// collection engine
	input  wire logic [CNT_W-1:0]  coll_count,
	// results
	output logic [7:0]             err_code,
	output logic                   err_flag,
	output logic [31:0]            ivl_eff,
	output logic                   ivl_slowed
);

	logic signed [31:0] prm [spc_p::N_PRM];
	logic [2:0]         mode;
	logic [5:0]         chan_en;
	logic [5:0]         eq_pend;
	logic [7:0]         cmd;
	logic [3:0]         n_prm;
	logic               go;
	logic               samp_go;
	logic               fetch_go;
	logic               stat_rd;
	logic [2:0]         n_chan;
	logic [2:0]         tch;
	logic               cnt_ok;
	logic               filt_ok;
	logic [31:0]        mem_need;
	logic               rng;
	logic               sel_ok;
	logic [4:0]         eq_need;
	logic               end_bad;
	logic [7:0]         chk_e;
	logic [7:0]         next_err;
	logic [31:0]        rd_mux;
	logic [31:0]        ivl_calc;
	logic               slow_calc;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [2:0] ch_idx(input logic signed [31:0] v);
		case (v)
		32'sd1:  return 3'd0;
		32'sd2:  return 3'd1;
		32'sd3:  return 3'd2;
		32'sd11: return 3'd3;
		32'sd21: return 3'd4;
		32'sd31: return 3'd5;
		default: return 3'd7;
		endcase
	endfunction

	function automatic logic in_rng(input logic signed [31:0] v,
		input int lo, input int hi);
		return v >= lo && v <= hi;
	endfunction

	function automatic logic pt_ok(input logic signed [31:0] v,
		input logic [CNT_W-1:0] n);
		return v == 0 || in_rng(v, 1, int'(n));
	endfunction

	function automatic logic [2:0] pop6(input logic [5:0] m);
		logic [2:0] c;
		c = 3'd0;
		for (int i = 0; i < 6; i++) begin
			c = c + 3'(m[i]);
		end
		return c;
	endfunction

	function automatic logic prm_hit(input logic [7:0] a);
		return a >= spc_p::A_PRM && a <= spc_p::A_PRM_HI;
	endfunction

	// ----------------------------------------
	// decode
	// ----------------------------------------
	assign cmd = bus_req.wdata[7:0];
	assign n_prm = bus_req.wdata[11:8];
	assign go = bus_req.wr && bus_req.addr == spc_p::A_CMD;
	assign samp_go = go && cmd == spc_p::C_SAMP;
	assign fetch_go = go && cmd == spc_p::C_FETCH;
	assign stat_rd = bus_req.rd && bus_req.addr == spc_p::A_STATUS;
	assign n_chan = pop6(chan_en);
	assign tch = ch_idx(prm[spc_p::P_TCH]);
	assign mem_need = 32'(prm[spc_p::P_CNT]) * 32'(n_chan);
	assign rng = prm[spc_p::P_CH] == spc_p::RNG_CH;

	always_comb begin
		if (mode[spc_p::MB_RT]) begin
			cnt_ok = prm[spc_p::P_CNT] == 1 ||
				(prm[spc_p::P_CNT] == 0 && mode[spc_p::MB_MAN]);
			filt_ok = prm[spc_p::P_FILT] inside {0, 7, 8, 9};
		end else begin
			cnt_ok = in_rng(prm[spc_p::P_CNT], 1, spc_p::NRT_CNT_MAX);
			filt_ok = in_rng(prm[spc_p::P_FILT], 0, spc_p::NRT_FILT_MAX);
		end
	end

	always_comb begin
		if (rng)
			sel_ok = prm[spc_p::P_SEL] == 0 ||
				prm[spc_p::P_SEL] == spc_p::ESEL_RNG;
		else
			sel_ok = in_rng(prm[spc_p::P_SEL], spc_p::ESEL_MIN,
				spc_p::ESEL_MAX);
		// analog lists carry order plus one constants after the header
		eq_need = rng ? 5'(spc_p::N_RNG) :
			5'(spc_p::N_EQ) + 5'(prm[spc_p::P_ORD]) + 5'd1;
		end_bad = !pt_ok(prm[spc_p::P_END], coll_count) ||
			(prm[spc_p::P_BEG] != 0 && prm[spc_p::P_END] != 0 &&
			prm[spc_p::P_END] < prm[spc_p::P_BEG]);
	end

	// ----------------------------------------
	// list checks, first failing field wins
	// ----------------------------------------
	always_comb begin
		chk_e = spc_p::E_NONE;
		case (cmd)
		spc_p::C_CHAN: begin
			if (n_prm < spc_p::N_CHAN)
				chk_e = spc_p::E_FEW;
			else if (ch_idx(prm[spc_p::P_CH]) == 3'd7)
				chk_e = spc_p::E_SCH;
		end
		spc_p::C_SAMP: begin
			if (chan_en == 6'h00)
				chk_e = spc_p::E_NOCH;
			else if (n_prm < spc_p::N_SAMP)
				chk_e = spc_p::E_FEW;
			else if (prm[spc_p::P_IVL] <= 0 ||
				prm[spc_p::P_IVL] >= spc_p::IVL_MAX)
				chk_e = spc_p::E_IVL;
			else if (!cnt_ok)
				chk_e = spc_p::E_CNT;
			else if (!in_rng(prm[spc_p::P_TTYP], 0, spc_p::TRIG_MAX))
				chk_e = spc_p::E_TRIG;
			else if (!(|(chan_en & (6'h01 << tch))))
				chk_e = spc_p::E_TCH;
			else if (!in_rng(prm[spc_p::P_PRE], 0, spc_p::PRE_MAX))
				chk_e = spc_p::E_PRE;
			else if (!in_rng(prm[spc_p::P_EXT], 0, 1))
				chk_e = spc_p::E_EXT;
			else if (!in_rng(prm[spc_p::P_REC], 0, spc_p::REC_MAX))
				chk_e = spc_p::E_REC;
			else if (!filt_ok)
				chk_e = spc_p::E_FILT; // and
			else if (!mode[spc_p::MB_RT] && mem_need > spc_p::MEM_SAMPLES)
				chk_e = spc_p::E_MEM;
		end
		spc_p::C_EQ: begin
			if (n_prm < spc_p::N_EQ)
				chk_e = spc_p::E_FEW;
			else if (!(prm[spc_p::P_CH] inside {[0:spc_p::ANA_MAX], spc_p::RNG_CH}))
				chk_e = spc_p::E_ECH;
			else if (prm[spc_p::P_CH] == 0)
				chk_e = spc_p::E_NONE;
			else if (!sel_ok)
				chk_e = spc_p::E_ESEL;
			else if (!rng && !in_rng(prm[spc_p::P_ORD], 1, spc_p::ORD_MAX))
				chk_e = spc_p::E_ORD;
			else if (5'(n_prm) < eq_need)
				chk_e = spc_p::E_FEW;
			else if (rng && !in_rng(prm[spc_p::P_UNIT], 0, spc_p::UNIT_MAX))
				chk_e = spc_p::E_UNIT;
		end
		spc_p::C_DATA: begin
			if (n_prm < spc_p::N_DATA)
				chk_e = spc_p::E_FEW;
			else if (ch_idx(prm[spc_p::P_CH]) == 3'd7)
				chk_e = spc_p::E_DCH;
			else if (!in_rng(prm[spc_p::P_GRP], 0, spc_p::GRP_MAX))
				chk_e = spc_p::E_GRP;
			else if (!pt_ok(prm[spc_p::P_BEG], coll_count))
				chk_e = spc_p::E_BEG;
			else if (end_bad)
				chk_e = spc_p::E_END;
		end
		spc_p::C_FETCH: begin
			if (eq_pend != 6'h00)
				chk_e = spc_p::E_NOEQ;
			else if (coll_count == '0)
				chk_e = spc_p::E_NODATA;
		end
		default: chk_e = spc_p::E_NONE;
		endcase
	end

	// ----------------------------------------
	// interval rounding
	// ----------------------------------------
	spc_ivl u_ivl (
		.req_ivl (prm[spc_p::P_IVL]),
		.fast    (mode[spc_p::MB_FAST]),
		.n_chan  (n_chan),
		.eff_ivl (ivl_calc),
		.slowed  (slow_calc)
	);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ivl_eff <= 32'h0000_0000;
			ivl_slowed <= 1'b0;
		end else if (samp_go && chk_e == spc_p::E_NONE) begin
			ivl_eff <= ivl_calc;
			ivl_slowed <= slow_calc;
		end
	end

	// ----------------------------------------
	// software-written state
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode <= 3'h0;
			for (int i = 0; i < spc_p::N_PRM; i++) begin
				prm[i] <= 32'sh0000_0000;
			end
		end else if (bus_req.wr) begin
			if (bus_req.addr == spc_p::A_MODE)
				mode <= bus_req.wdata[2:0];
			if (prm_hit(bus_req.addr))
				prm[bus_req.addr[4:2]] <= bus_req.wdata;
		end
	end

	// ----------------------------------------
	// channel and equation bookkeeping
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			chan_en <= 6'h00;
			eq_pend <= 6'h00;
		end else if (go && chk_e == spc_p::E_NONE) begin
			if (cmd == spc_p::C_CHAN) begin
				chan_en[ch_idx(prm[spc_p::P_CH])] <= prm[spc_p::P_OP] != 0;
				eq_pend[ch_idx(prm[spc_p::P_CH])] <=
					prm[spc_p::P_OP] != 0 && prm[spc_p::P_EQON] == 1;
			end else if (cmd == spc_p::C_EQ) begin
				if (prm[spc_p::P_CH] == 0)
					eq_pend <= 6'h00;
				else
					eq_pend[ch_idx(prm[spc_p::P_CH])] <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// error code
	// ----------------------------------------
	// a new error beats the clear of a status read in the same cycle
	always_comb begin
		next_err = err_code;
		if (go && chk_e != spc_p::E_NONE)
			next_err = chk_e;
		else if (stat_rd)
			next_err = spc_p::E_NONE;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			err_code <= spc_p::E_NONE;
			err_flag <= 1'b0;
		end else begin
			err_code <= next_err;
			err_flag <= next_err != spc_p::E_NONE;
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (bus_req.addr)
		spc_p::A_MODE:   rd_mux = {29'h0, mode};
		spc_p::A_STATUS: rd_mux = {24'h0, err_code};
		spc_p::A_INFO:   rd_mux = {20'h0, eq_pend, chan_en};
		spc_p::A_IVL:    rd_mux = ivl_eff;
		default: begin
			if (prm_hit(bus_req.addr))
				rd_mux = prm[bus_req.addr[4:2]];
		end
		endcase
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			rd_data <= 32'h0000_0000;
		else
			rd_data <= bus_req.rd ? rd_mux : 32'h0000_0000;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	chk_rt_filter: assert property (
		samp_go && chk_e == spc_p::E_FILT && mode[spc_p::MB_RT]
		|-> !(prm[spc_p::P_FILT] inside {0, 7, 8, 9}))
		else $error("real time filter refused wrongly");

	chk_nrt_filter: assert property (
		samp_go && !mode[spc_p::MB_RT] && chk_e != spc_p::E_FILT &&
		!(prm[spc_p::P_FILT] inside {[0:6]})
		|-> chk_e != spc_p::E_NONE)
		else $error("bad filter accepted");

	chk_no_chan: assert property (
		samp_go && chan_en == 6'h00 |=> err_code == spc_p::E_NOCH)
		else $error("sampling without channels not refused");

	chk_ivl_round: assert property (
		samp_go && chk_e == spc_p::E_NONE && !slow_calc
		|=> ivl_eff % ($past(mode[spc_p::MB_FAST]) ?
		spc_p::FAST_STEP : spc_p::SLOW_STEP) == 0)
		else $error("interval not rounded");

	chk_ivl_slow: assert property (
		samp_go && chk_e == spc_p::E_NONE
		|=> ivl_eff >= 32'($past(n_chan)) * spc_p::CH_TICKS && ivl_eff != 0)
		else $error("interval faster than channels allow");

	chk_mem_limit: assert property (
		samp_go && chk_e == spc_p::E_NONE && !mode[spc_p::MB_RT]
		|-> mem_need <= spc_p::MEM_SAMPLES)
		else $error("storage limit passed");

	chk_fetch_eq: assert property (
		fetch_go && eq_pend != 6'h00 |=> err_code == spc_p::E_NOEQ)
		else $error("pending equation not reported");

	chk_no_data: assert property (
		fetch_go && eq_pend == 6'h00 && coll_count == '0
		|=> err_code == spc_p::E_NODATA && err_flag)
		else $error("empty fetch not refused");

	chk_stat_read: assert property (
		stat_rd |=> rd_data == 32'($past(err_code)) &&
		err_code == spc_p::E_NONE)
		else $error("status read wrong");

	chk_err_hold: assert property (
		!stat_rd && !(go && chk_e != spc_p::E_NONE) |=> $stable(err_code))
		else $error("error code changed on its own");

	cov_samp_ok: cover property (samp_go && chk_e == spc_p::E_NONE);
	cov_slowed: cover property (samp_go && chk_e == spc_p::E_NONE && slow_calc);
	cov_err_read: cover property (go && chk_e != spc_p::E_NONE ##[1:4] stat_rd);

endmodule // spc_checker

// ===== spc_p.sv
/*
 spc_p: constants and carrier types of the setup parameter checker.
 assumes a single clock domain and a word-wide register port.
*/
// Functional notes
// - real time filter only 0, 7, 8, 9
// - non-real-time filter 0 to 6, else 30
// - sampling setup before channel setup gives 31
// - interval at or below 0, or >= 16000 s: 32
// - interval rounds to 100 us, 50 us fast
// - too-fast interval is slowed, not refused
// - count 1 real time, 1..12000 otherwise: 33; real time with the manual mode bit also takes 0
// - trigger type 0 to 6, else 34
// - trigger channel must be enabled, else 35
// - pre-trigger percent 0 to 100, else 37
// - external timing 0 or 1, else 38
// - record time 0 to 2, else 39
// - too few list parameters give 40
// - equation channel 0, 1-3, 11, else 42
// - selector 0.1-12 analog, 0/13 ranging: 43
// - order unfit for equation type gives 44
// - pending or missing equation at fetch: 45
// - temperature unit 0 to 4, else 49
// - data channel 1-3, 11, 21, 31, else 52
// - data group 0 to 5, else 53
// - start/end points in range, ordered: 54/55
// - over 12K samples stored gives 61
// - return with nothing collected gives 62
// - status read reports latest code, 0 none
package spc_p;

	// ----------------------------------------
	// register offsets and mode bits
	// ----------------------------------------
	localparam logic [7:0] A_CMD    = 8'h00;
	localparam logic [7:0] A_MODE   = 8'h04;
	localparam logic [7:0] A_STATUS = 8'h08;
	localparam logic [7:0] A_INFO   = 8'h0C;
	localparam logic [7:0] A_IVL    = 8'h10;
	localparam logic [7:0] A_PRM    = 8'h20;
	localparam logic [7:0] A_PRM_HI = 8'h3C;
	localparam int         N_PRM    = 8;
	localparam int         MB_RT    = 0;
	localparam int         MB_FAST  = 1;
	localparam int         MB_MAN   = 2;

	// ----------------------------------------
	// commands, field positions, list lengths
	// ----------------------------------------
	localparam logic [7:0] C_CHAN  = 8'h01;
	localparam logic [7:0] C_SAMP  = 8'h03;
	localparam logic [7:0] C_EQ    = 8'h04;
	localparam logic [7:0] C_DATA  = 8'h05;
	localparam logic [7:0] C_FETCH = 8'h07;
	localparam int P_CH = 0, P_OP = 1, P_EQON = 2;
	localparam int P_SEL = 1, P_ORD = 2, P_UNIT = 3;
	localparam int P_GRP = 1, P_BEG = 2, P_END = 3;
	localparam int P_IVL = 0, P_CNT = 1, P_TTYP = 2, P_TCH = 3;
	localparam int P_PRE = 4, P_EXT = 5, P_REC = 6, P_FILT = 7;
	localparam logic [3:0] N_CHAN = 4'h3;
	localparam logic [3:0] N_SAMP = 4'h8;
	localparam logic [3:0] N_EQ   = 4'h3;
	localparam logic [3:0] N_RNG  = 4'h4;
	localparam logic [3:0] N_DATA = 4'h4;

	// ----------------------------------------
	// error codes
	// ----------------------------------------
	localparam logic [7:0] E_NONE = 8'h00, E_SCH = 8'h0C;
	localparam logic [7:0] E_FILT = 8'h1E, E_NOCH = 8'h1F;
	localparam logic [7:0] E_IVL = 8'h20, E_CNT = 8'h21;
	localparam logic [7:0] E_TRIG = 8'h22, E_TCH = 8'h23;
	localparam logic [7:0] E_PRE = 8'h25, E_EXT = 8'h26;
	localparam logic [7:0] E_REC = 8'h27, E_FEW = 8'h28;
	localparam logic [7:0] E_ECH = 8'h2A, E_ESEL = 8'h2B;
	localparam logic [7:0] E_ORD = 8'h2C, E_NOEQ = 8'h2D;
	localparam logic [7:0] E_UNIT = 8'h31, E_DCH = 8'h34;
	localparam logic [7:0] E_GRP = 8'h35, E_BEG = 8'h36;
	localparam logic [7:0] E_END = 8'h37, E_MEM = 8'h3D;
	localparam logic [7:0] E_NODATA = 8'h3E;

	// ----------------------------------------
	// limits and interval timing
	// ----------------------------------------
	localparam int NRT_FILT_MAX = 6, TRIG_MAX = 6, PRE_MAX = 100;
	localparam int REC_MAX = 2, UNIT_MAX = 4, GRP_MAX = 5;
	localparam int NRT_CNT_MAX = 12000, MEM_SAMPLES = 12 * 1024;
	localparam int ESEL_MIN = 1, ESEL_MAX = 120, ESEL_RNG = 130;
	localparam int ORD_MAX = 4, ANA_MAX = 3, RNG_CH = 11;
	localparam int UNIT_US = 10;
	localparam int ROUND_US = 100, FAST_ROUND_US = 50;
	localparam int SLOW_STEP = ROUND_US / UNIT_US;
	localparam int FAST_STEP = FAST_ROUND_US / UNIT_US;
	localparam longint IVL_MAX_S = 16000;
	localparam int IVL_MAX = int'(IVL_MAX_S * 64'd1000000 / UNIT_US);
	localparam int CH_US = 20;
	localparam int CH_TICKS = CH_US / UNIT_US;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} spc_bus_t;

endpackage

// ===== spc_ivl.sv
/*
 spc_ivl: rounds a requested sample interval and slows it when the
 enabled channels need more time. assumes interval lsb of 10 us.
*/
`timescale 1ns/100ps
module spc_ivl #(
	parameter int W = 32
) (
	// request
	input  wire logic signed [W-1:0] req_ivl,
	input  wire logic                fast,
	input  wire logic [2:0]          n_chan,
	// result
	output logic [W-1:0]             eff_ivl,
	output logic                     slowed
);

	logic [W-1:0] step;
	logic [W-1:0] rnd;
	logic [W-1:0] floor_ivl;

	// ----------------------------------------
	// rounding and slow-down
	// ----------------------------------------
	// divide by a small constant step; area over speed, one use only
	always_comb begin
		step = fast ? W'(spc_p::FAST_STEP) : W'(spc_p::SLOW_STEP);
		rnd = ((W'(req_ivl) + (step >> 1)) / step) * step;
		floor_ivl = W'(n_chan) * W'(spc_p::CH_TICKS);
		slowed = rnd < floor_ivl;
		eff_ivl = slowed ? floor_ivl : rnd;
	end

endmodule // spc_ivl

// ===== spc_host.sv
/*
 spc_host: host model that drives the register port, one strobe at a time.
 assumes the bench calls its tasks just after a rising edge of sys_clk.
*/
`timescale 1ns/100ps
module spc_host (
	// clock
	input  wire logic       sys_clk,
	// register port
	output spc_p::spc_bus_t bus_req
);
	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	initial begin
		bus_req = '0;
	end
	// idle lines flip, so stale address or data never pass for a request
	task automatic idle();
		bus_req.wr    <= 1'b0;
		bus_req.rd    <= 1'b0;
		bus_req.addr  <= ~bus_req.addr;
		bus_req.wdata <= ~bus_req.wdata;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus_req.addr  <= a;
		bus_req.wdata <= d;
		bus_req.wr    <= 1'b1;
		@(posedge sys_clk);
		idle();
	endtask
	// reads the register at address a with one read strobe, then idles
	task automatic rd(input logic [7:0] a);
		bus_req.addr <= a;
		bus_req.rd   <= 1'b1;
		@(posedge sys_clk);
		idle();
	endtask
endmodule // spc_host

// ===== setup_command_param_checker_tb.sv
/*
 setup_command_param_checker_tb: self-checking bench of spc_checker.
 assumes spc_host as bus master and a 20 MHz clock.
*/
`timescale 1ns/100ps
module setup_command_param_checker_tb;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic            sys_clk;
	logic            sys_rst;
	spc_p::spc_bus_t bus_req;
	logic [15:0]     coll_count;
	logic [31:0]     rd_data;
	logic [31:0]     ivl_eff;
	logic [7:0]      err_code;
	logic            err_flag;
	logic            ivl_slowed;
	logic            rd_seen = 1'b0;
	int              mismatches = 0;
	int              checked = 0;
	int              cycles = 0;
	logic [31:0]     exp_q[$];
	logic [31:0]     p[8];
	logic [31:0]     base[8] = '{32'h64, 32'hA, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};

	spc_checker #(.CNT_W(16)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(bus_req),
		.rd_data(rd_data), .coll_count(coll_count), .err_code(err_code),
		.err_flag(err_flag), .ivl_eff(ivl_eff), .ivl_slowed(ivl_slowed));
	spc_host host (.sys_clk(sys_clk), .bus_req(bus_req));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// compare and report
	// ----------------------------------------
	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t read %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp1(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// read data stand only in the cycle after the strobe
	always @(posedge sys_clk) begin
		if (rd_seen) begin
			if (exp_q.size() == 0) begin
				mismatches++;
				$display("MISMATCH %0t unexpected read", $time);
			end else
				cmp32(rd_data, exp_q.pop_front());
		end
		rd_seen <= bus_req.rd;
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			close_out();
		end
	end

	// ----------------------------------------
	// command helpers
	// ----------------------------------------
	task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		host.rd(a);
	endtask
	task automatic issue(input logic [7:0] cmd, input logic [3:0] n);
		for (int i = 0; i < 8; i++)
			host.wr(spc_p::A_PRM + 8'(4 * i), p[i]);
		host.wr(spc_p::A_CMD, {20'h0, n, cmd});
	endtask
	// flag rises with an error, then status read reports and clears it
	task automatic run(input logic [7:0] cmd, input logic [3:0] n, input logic [7:0] e);
		issue(cmd, n);
		#1 cmp1(err_flag, e != 8'h00);
		cmp32({24'h0, err_code}, {24'h0, e});
		rd_exp(spc_p::A_STATUS, {24'h0, e});
		#1 cmp1(err_flag, 1'b0);
	endtask
	task automatic samp(input int i, input logic [31:0] v, input logic [7:0] e);
		p = base;
		p[i] = v;
		run(spc_p::C_SAMP, 4'h8, e);
	endtask
	task automatic chan(input logic [31:0] ch, input logic [31:0] eq);
		p = '{ch, 32'h1, eq, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
		run(spc_p::C_CHAN, 4'h3, 8'h00);
	endtask
	task automatic eqn(input logic [31:0] ch, input logic [31:0] sel, input logic [31:0] ord,
		input logic [31:0] unit, input logic [3:0] n, input logic [7:0] e);
		p = '{ch, sel, ord, unit, 32'h0, 32'h0, 32'h0, 32'h0};
		run(spc_p::C_EQ, n, e);
	endtask
	task automatic dctl(input logic [31:0] ch, input logic [31:0] g, input logic [31:0] b,
		input logic [31:0] en, input logic [7:0] e);
		p = '{ch, g, b, en, 32'h0, 32'h0, 32'h0, 32'h0};
		run(spc_p::C_DATA, 4'h4, e);
	endtask
	task automatic ivl(input logic [31:0] m, input logic [31:0] v, input logic [31:0] eff,
		input logic slw);
		host.wr(spc_p::A_MODE, m);
		samp(0, v, 8'h00);
		rd_exp(spc_p::A_IVL, eff);
		#1 cmp1(ivl_slowed, slw);
		cmp32(ivl_eff, eff);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		sys_rst = 1'b1;
		coll_count = 16'h0;
		p = base;
		void'($urandom(32'h1BEE123C));
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		rd_exp(spc_p::A_STATUS, 32'h0);
		rd_exp(8'h40, 32'h0);
		samp(0, 32'h64, spc_p::E_NOCH);
		run(spc_p::C_CHAN, 4'h2, spc_p::E_FEW);
		chan(32'h1, 32'h1);
		rd_exp(spc_p::A_INFO, 32'h41);
		run(spc_p::C_FETCH, 4'h0, spc_p::E_NOEQ);
		eqn(32'h1, 32'h32, 32'h2, 32'h0, 4'h5, spc_p::E_FEW);
		eqn(32'h5, 32'h32, 32'h2, 32'h0, 4'h6, spc_p::E_ECH);
		eqn(32'h1, 32'h0, 32'h2, 32'h0, 4'h6, spc_p::E_ESEL);
		eqn(32'h1, 32'h79, 32'h2, 32'h0, 4'h6, spc_p::E_ESEL);
		eqn(32'hB, 32'h78, 32'h0, 32'h0, 4'h4, spc_p::E_ESEL);
		eqn(32'h1, 32'h32, 32'h5, 32'h0, 4'h9, spc_p::E_ORD);
		eqn(32'hB, 32'h82, 32'h0, 32'h5, 4'h4, spc_p::E_UNIT);
		eqn(32'hB, 32'h82, 32'h0, 32'h4, 4'h4, 8'h00);
		eqn(32'h1, 32'h78, 32'h4, 32'h0, 4'h8, 8'h00);
		rd_exp(spc_p::A_INFO, 32'h1);
		chan(32'h1, 32'h1);
		eqn(32'h0, 32'h0, 32'h0, 32'h0, 4'h3, 8'h00);
		rd_exp(spc_p::A_INFO, 32'h1);
		run(spc_p::C_FETCH, 4'h0, spc_p::E_NODATA);
		host.wr(spc_p::A_MODE, 32'h0);
		samp(0, 32'h0, spc_p::E_IVL);
		samp(0, 32'hFFFFFFFF, spc_p::E_IVL);
		samp(0, 32'h5F5E1000, spc_p::E_IVL);
		samp(0, 32'h5F5E0FFF, 8'h00);
		samp(1, 32'h0, spc_p::E_CNT);
		samp(1, 32'h2EE1, spc_p::E_CNT);
		samp(1, 32'h2EE0, 8'h00);
		samp(2, 32'h7, spc_p::E_TRIG);
		samp(3, 32'h2, spc_p::E_TCH);
		samp(4, 32'h65, spc_p::E_PRE);
		samp(4, 32'h64, 8'h00);
		samp(5, 32'h2, spc_p::E_EXT);
		samp(6, 32'h3, spc_p::E_REC);
		samp(7, 32'h7, spc_p::E_FILT);
		samp(7, 32'h6, 8'h00);
		p = base;
		run(spc_p::C_SAMP, 4'h7, spc_p::E_FEW);
		repeat (8) begin
			r = $urandom_range(15);
			samp(2, r, (r > 6) ? spc_p::E_TRIG : 8'h00);
		end
		host.wr(spc_p::A_MODE, 32'h1);
		base[1] = 32'h1;
		samp(7, 32'h6, spc_p::E_FILT);
		foreach (base[i]) if (i < 4) samp(7, (i == 0) ? 32'h0 : 32'h6 + i, 8'h00);
		samp(1, 32'h2, spc_p::E_CNT);
		samp(1, 32'h0, spc_p::E_CNT);
		host.wr(spc_p::A_MODE, 32'h5);
		rd_exp(spc_p::A_MODE, 32'h5);
		samp(1, 32'h0, 8'h00);
		base[1] = 32'hA;
		ivl(32'h0, 32'h68, 32'h64, 1'b0);
		ivl(32'h0, 32'h6A, 32'h6E, 1'b0);
		ivl(32'h2, 32'h67, 32'h69, 1'b0);
		ivl(32'h0, 32'h1, 32'h2, 1'b1);
		chan(32'h2, 32'h0);
		ivl(32'h0, 32'h1, 32'h4, 1'b1);
		samp(1, 32'h1801, spc_p::E_MEM);
		samp(1, 32'h1800, 8'h00);
		p = base;
		p[2] = 32'h7;
		issue(spc_p::C_SAMP, 4'h8);
		p = base;
		issue(spc_p::C_SAMP, 4'h8);
		#1 cmp1(err_flag, 1'b1);
		rd_exp(spc_p::A_STATUS, {24'h0, spc_p::E_TRIG});
		p[5] = 32'h2;
		issue(spc_p::C_SAMP, 4'h8);
		p = base;
		p[6] = 32'h3;
		issue(spc_p::C_SAMP, 4'h8);
		rd_exp(spc_p::A_STATUS, {24'h0, spc_p::E_REC});
		coll_count <= 16'h14;
		foreach (base[i]) if (i < 6) dctl((i < 3) ? i + 1 : 32'hB + 10 * (i - 3), 32'h0, 32'h0,
			32'h0, 8'h00);
		dctl(32'h4, 32'h0, 32'h0, 32'h0, spc_p::E_DCH);
		dctl(32'h1, 32'h6, 32'h0, 32'h0, spc_p::E_GRP);
		dctl(32'h1, 32'h5, 32'h15, 32'h0, spc_p::E_BEG);
		dctl(32'h1, 32'h0, 32'hFFFFFFFF, 32'h0, spc_p::E_BEG);
		dctl(32'h1, 32'h0, 32'h0, 32'h15, spc_p::E_END);
		dctl(32'h1, 32'h0, 32'hA, 32'h5, spc_p::E_END);
		dctl(32'h1, 32'h0, 32'h14, 32'h14, 8'h00);
		run(spc_p::C_FETCH, 4'h0, 8'h00);
		repeat (2) @(posedge sys_clk);
		close_out();
	end
endmodule // setup_command_param_checker_tb
